// file: hbdc_pkg.sv
// Purpose: constants shared by the bridge input controller
// Assumes: 10 MHz clock
// Notes:   all timing counts derived from printed times
package hbdc_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned MIN_PULSE_NS  = 1000;
    localparam int unsigned MIN_GAP_NS    = 1000;
    localparam int unsigned SAFE_GAP_NS   = 500;
    localparam int unsigned NS_PER_S      = 1_000_000_000;
    localparam int unsigned GAP_CYC =
        (MIN_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PULSE_CYC =
        (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SAFE_CYC =
        (SAFE_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // ----------------------------------------------------------------
    // modes and pwm settings
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_ANTI  = 2'h1;
    localparam logic [1:0] MODE_SIGN  = 2'h2;
    localparam logic [1:0] MODE_BRAKE = 2'h3;
    localparam logic [7:0] HALF_DUTY  = 8'h80;
    localparam int unsigned PERIOD_W  = 8;
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h64;
endpackage

// file: hbdc_pin_if.sv
// Purpose: carries the three bridge inputs from sequencer to pins
// Assumes: one clock domain
// Notes:   want is requested level, pin is spaced level
`timescale 1ns/100ps
interface hbdc_pin_if;
    logic [2:0] want;
    logic [2:0] pin;
    logic       busy;
    modport ctl (output want, input pin, input busy);
    modport seq (input want, output pin, output busy);
endinterface

// file: hbdc_spacer.sv
// Purpose: applies bridge input changes one at a time, spaced apart
// Assumes: want from logic on the same clock
// Notes:   bit 0 direction, bit 1 brake, bit 2 modulation
`timescale 1ns/100ps
module hbdc_spacer #(
    parameter int unsigned GAP = hbdc_pkg::GAP_CYC
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    hbdc_pin_if.seq   p
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    initial begin
        if (GAP < hbdc_pkg::PULSE_CYC || GAP < hbdc_pkg::SAFE_CYC ||
            GAP > 255) begin
            $error("hbdc_spacer: GAP out of range");
        end
    end
    // ----------------------------------------------------------------
    // spacing
    // ----------------------------------------------------------------
    logic [7:0] gap_cnt;
    logic [2:0] diff;
    logic [2:0] pick;
    assign diff = p.want ^ p.pin;
    // priority: rising modulation first, so it rises before brake rises
    always_comb begin
        pick = 3'h0;
        if (diff[2] && p.want[2]) begin
            pick = 3'h4;
        end else if (diff[1]) begin
            pick = 3'h2;
        end else if (diff[2]) begin
            pick = 3'h4;
        end else if (diff[0]) begin
            pick = 3'h1;
        end
    end
    // one edge per gap window, no edge aligned
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            p.pin   <= 3'h2; // brake high, modulation low
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'h00) begin
            gap_cnt <= gap_cnt - 8'h01;
        end else if (pick != 3'h0) begin
            p.pin   <= p.pin ^ pick;
            gap_cnt <= 8'(GAP - 1); // also holds pulse width
        end
    end
    assign p.busy = (gap_cnt != 8'h00) || (diff != 3'h0);
endmodule

// file: hbdc_top.sv
// Purpose: motion controller driving an H-bridge's three logic inputs
// Assumes: warning pin is asynchronous, open collector, active low
// Notes:   direction, brake and modulation leave through spacing
//
// Overview of operation
// - controller holds modulation high whenever brake is high, except in off mode (brake high, modulation low)
// - anti-phase mode: modulation high, duty on direction, half is zero
// - sign mode: polarity on direction, duty pulses on modulation
// - space any two input transitions by at least one microsecond
// - keep at least 500 ns between consecutive transitions
// - every input pulse at least one microsecond wide
// - warning is open collector, wired-OR low with pull-up
// - warning treated as interrupt: reduce current or shut down
`timescale 1ns/100ps
module hbdc_top #(
    parameter int unsigned PERIOD_W = hbdc_pkg::PERIOD_W,
    parameter int unsigned GAP      = hbdc_pkg::GAP_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic [1:0]          mode_i,
    input  wire logic [7:0]          duty_i,
    input  wire logic                dir_i,
    input  wire logic [PERIOD_W-1:0] period_i,
    input  wire logic                warn_n_i,
    input  wire logic                derate_i,
    output logic                     dir_o,
    output logic                     brake_o,
    output logic                     mod_o,
    output logic                     warn_o,
    output logic                     busy_o
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    initial begin
        if (PERIOD_W < 8 || PERIOD_W > 16) begin
            $error("hbdc_top: PERIOD_W out of range");
        end
    end
    // ----------------------------------------------------------------
    // warning input
    // ----------------------------------------------------------------
    logic warn_s1;
    logic warn_s2;
    logic warn_q;
    // two-stage synchroniser on the wired-OR pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            warn_s1 <= 1'b1;
            warn_s2 <= 1'b1;
        end else begin
            warn_s1 <= warn_n_i;
            warn_s2 <= warn_s1;
        end
    end
    // active low warning raises the request level
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            warn_q <= 1'b0;
        end else begin
            warn_q <= ~warn_s2;
        end
    end
    // ----------------------------------------------------------------
    // pwm timebase
    // ----------------------------------------------------------------
    // each pwm slot is GAP clocks long, so every pulse and gap is spaced
    logic [PERIOD_W-1:0] slot_cnt;
    logic [7:0]          tick_cnt;
    logic [PERIOD_W-1:0] slot_max;
    logic                slot_adv;
    assign slot_max = (period_i < PERIOD_W'(4)) ? PERIOD_W'(4) : period_i;
    assign slot_adv = (tick_cnt == 8'(GAP - 1));
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tick_cnt <= 8'h00;
        end else if (slot_adv) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            slot_cnt <= '0;
        end else if (slot_adv) begin
            if (slot_cnt >= slot_max - PERIOD_W'(1)) begin
                slot_cnt <= '0;
            end else begin
                slot_cnt <= slot_cnt + PERIOD_W'(1);
            end
        end
    end
    // ----------------------------------------------------------------
    // duty compare
    // ----------------------------------------------------------------
    logic [7:0]          eff_duty;
    logic [PERIOD_W+7:0] on_prod;
    logic [PERIOD_W-1:0] on_slots;
    logic                pwm_on;
    // warning derates amplitude to half when enabled
    always_comb begin
        eff_duty = duty_i;
        if (warn_q && derate_i) begin
            if (mode_i == hbdc_pkg::MODE_ANTI) begin
                eff_duty = 8'(({1'b0, duty_i} + {1'b0, hbdc_pkg::HALF_DUTY})
                              >> 1);
            end else begin
                eff_duty = {1'b0, duty_i[7:1]};
            end
        end
    end
    assign on_prod  = slot_max * eff_duty;
    assign on_slots = on_prod[PERIOD_W+7:8];
    assign pwm_on   = slot_cnt < on_slots;
    // ----------------------------------------------------------------
    // requested bridge inputs
    // ----------------------------------------------------------------
    hbdc_pin_if pins ();
    logic [2:0] next_want;
    always_comb begin
        next_want = 3'h0;
        unique case (mode_i)
            hbdc_pkg::MODE_OFF: begin
                next_want = 3'h2; // brake high, modulation low
            end
            hbdc_pkg::MODE_ANTI: begin
                // modulation high, duty on direction
                next_want = {1'b1, 1'b0, pwm_on};
            end
            hbdc_pkg::MODE_SIGN: begin
                // polarity plus amplitude pulses
                next_want = {pwm_on, 1'b0, dir_i};
            end
            hbdc_pkg::MODE_BRAKE: begin
                // brake only with modulation high
                next_want = {1'b1, 1'b1, dir_i};
            end
        endcase
    end
    logic [2:0] want_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            want_q <= 3'h2;
        end else begin
            want_q <= next_want;
        end
    end
    assign pins.want = want_q;
    hbdc_spacer #(
        .GAP (GAP)
    ) u_spacer (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .p       (pins)
    );
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dir_o   <= 1'b0;
            brake_o <= 1'b1;
            mod_o   <= 1'b0;
            warn_o  <= 1'b0;
            busy_o  <= 1'b0;
        end else begin
            dir_o   <= pins.pin[0];
            brake_o <= pins.pin[1];
            mod_o   <= pins.pin[2];
            warn_o  <= warn_q;
            busy_o  <= pins.busy;
        end
    end
endmodule

// file: hbdc_sva.sv
// Purpose: watches pin order, spacing and warning follow-up
// Assumes: GAP clocks per pin change, settled after 60 quiet clocks
// Notes:   bound to hbdc_top
`timescale 1ns/100ps
module hbdc_sva #(
    parameter int unsigned PERIOD_W = 8,
    parameter int unsigned GAP      = 10
) (
    input logic                clk_i,
    input logic                reset_i,
    input logic [1:0]          mode_i,
    input logic [7:0]          duty_i,
    input logic                dir_i,
    input logic [PERIOD_W-1:0] period_i,
    input logic                warn_n_i,
    input logic                derate_i,
    input logic                dir_o,
    input logic                brake_o,
    input logic                mod_o,
    input logic                warn_o,
    input logic                busy_o
);
    logic [2:0] prev;
    logic [2:0] req;
    logic [7:0] since;
    logic [5:0] quiet;
    logic       chg;
    logic       calm;
    assign chg  = prev != {dir_o, brake_o, mod_o};
    assign calm = (quiet >= 6'h3C) && (req == {mode_i, dir_i});
    always_ff @(posedge clk_i) begin
        prev  <= {dir_o, brake_o, mod_o};
        req   <= {mode_i, dir_i};
        since <= reset_i ? 8'hFF : chg ? 8'h01 :
                 since + {7'h0, since != 8'hFF};
        quiet <= (reset_i || req != {mode_i, dir_i}) ? 6'h0 :
                 quiet + {5'h0, quiet != 6'h3F};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence held_low;  !warn_n_i [*5]; endsequence
    sequence held_high; warn_n_i [*5]; endsequence
    reset_state_a: assert property ($fell(reset_i) |-> brake_o
        && !mod_o && !dir_o && !warn_o && !busy_o) else $error("reset");
    pin_gap_a: assert property (chg |-> since >= GAP)
        else $error("pins too close");
    brake_mod_a: assert property ($rose(brake_o) |-> mod_o)
        else $error("brake without modulation");
    warn_set_a: assert property (held_low |-> warn_o)
        else $error("warning lost");
    warn_clr_a: assert property (held_high |-> !warn_o)
        else $error("warning stuck");
    warn_sync_a: assert property ($fell(warn_n_i) && !warn_o
        |=> !warn_o) else $error("warning not synchronised");
    settle_brake_a: assert property (calm && mode_i == 2'h3
        |-> brake_o && mod_o && dir_o == dir_i) else $error("brake");
    settle_off_a: assert property (calm && mode_i == 2'h0
        |-> brake_o && !mod_o && !busy_o) else $error("off");
    anti_mod_a: assert property (calm && mode_i == 2'h1
        |-> mod_o && !brake_o) else $error("anti-phase");
    sign_dir_a: assert property (calm && mode_i == 2'h2
        |-> dir_o == dir_i && !brake_o) else $error("sign");
endmodule
bind hbdc_top hbdc_sva #(.PERIOD_W(PERIOD_W), .GAP(GAP)) hbdc_sva_inst (
    .clk_i(clk_i), .reset_i(reset_i), .mode_i(mode_i), .duty_i(duty_i),
    .dir_i(dir_i), .period_i(period_i), .warn_n_i(warn_n_i),
    .derate_i(derate_i), .dir_o(dir_o), .brake_o(brake_o), .mod_o(mod_o),
    .warn_o(warn_o), .busy_o(busy_o));

// file: hbdc_bridge.sv
// Purpose: bridge logic model, truth table and thermal flag
// Assumes: combinational device, no clock
// Notes:   drv_o is {source1, sink1, source2, sink2}
`timescale 1ns/100ps
module hbdc_bridge (
    input  logic       dir_i,
    input  logic       brake_i,
    input  logic       mod_i,
    input  logic       hot_i,
    input  logic       shut_i,
    input  logic       trip_i,
    output logic [3:0] drv_o,
    output wire        warn_n_o
);
    always_comb begin
        drv_o = 4'h0;
        // overcurrent trip drops drivers, retry resumes once it clears
        if (shut_i || trip_i) drv_o = 4'h0;
        else if (!brake_i) drv_o = !mod_i ? 4'hA :
            dir_i ? 4'h9 : 4'h6;
        else if (mod_i) drv_o = dir_i ? 4'hA : 4'h5;
    end
    assign warn_n_o = hot_i ? 1'h0 : 1'hz;
endmodule

// file: hbdc_top_bench.sv
// Purpose: bench for the bridge input controller
// Assumes: bridge model on the pins, pulled-up warning wire
// Notes:   inputs change 10 ns after each rising edge
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    failures++; $display("CHECK FAILED %0t mismatch", $time); end end
module hbdc_top_bench;
    logic        clk_i = 1'h0, reset_i = 1'h1, dir_i = 1'h0;
    logic        derate_i = 1'h0, hot = 1'h0, shut = 1'h0, trip = 1'h0;
    logic [1:0]  mode_i = 2'h0;
    logic [7:0]  duty_i = 8'h0, period_i = 8'h04;
    logic        dir_o, brake_o, mod_o, warn_o, busy_o;
    logic [3:0]  drv;
    logic [15:0] seen;
    tri1         warn_n;
    int          failures = 0, comparisons = 0, cyc = 0, h1, h2;
    always #50 clk_i = ~clk_i;
    hbdc_top hbdc_top_inst (.clk_i(clk_i), .reset_i(reset_i),
        .mode_i(mode_i), .duty_i(duty_i), .dir_i(dir_i),
        .period_i(period_i), .warn_n_i(warn_n), .derate_i(derate_i),
        .dir_o(dir_o), .brake_o(brake_o), .mod_o(mod_o),
        .warn_o(warn_o), .busy_o(busy_o));
    hbdc_bridge hbdc_bridge_inst (.dir_i(dir_o), .brake_i(brake_o),
        .mod_i(mod_o), .hot_i(hot), .shut_i(shut), .trip_i(trip),
        .drv_o(drv), .warn_n_o(warn_n));
    task automatic conclude;
        if (failures == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            conclude;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask
    task automatic go(input logic [1:0] m, input logic [7:0] d,
                      input logic r);
        tick(1);
        mode_i = m;
        duty_i = d;
        dir_i = r;
        tick(80);
        seen = 16'h0;
    endtask
    task automatic run(output int h);
        h = 0;
        repeat (400) begin
            tick(1);
            h += dir_o;
            seen[drv] = 1'h1;
        end
    endtask
    task automatic t_reset;
        mode_i = 2'h0;
        reset_i = 1'h1;
        tick(20);
        reset_i = 1'h0;
        tick(1);
        `CHK({dir_o, brake_o, mod_o, busy_o, warn_o}, 5'h08)
        `CHK(drv, 4'h0)
    endtask
    task automatic t_brake(input logic r);
        go(hbdc_pkg::MODE_BRAKE, 8'h00, r);
        `CHK(drv, r ? 4'hA : 4'h5)
        `CHK(busy_o, 1'h0)
        go(hbdc_pkg::MODE_OFF, 8'h00, r);
        `CHK(drv, 4'h0)
    endtask
    task automatic t_sign(input logic r);
        go(hbdc_pkg::MODE_SIGN, 8'h80, r);
        run(h1);
        `CHK(seen, r ? 16'h0600 : 16'h0440)
    endtask
    task automatic t_anti;
        go(hbdc_pkg::MODE_ANTI, hbdc_pkg::HALF_DUTY, 1'h0);
        run(h1);
        `CHK(seen, 16'h0240)
        `CHK(h1 inside {[160:240]}, 1'h1)
    endtask
    task automatic t_warn;
        go(hbdc_pkg::MODE_ANTI, 8'hFF, 1'h0);
        run(h1);
        hot = 1'h1;
        derate_i = 1'h1;
        tick(6);
        `CHK(warn_o, 1'h1)
        run(h2);
        `CHK(h2 < h1, 1'h1)
        `CHK(seen, 16'h0240)
        shut = 1'h1;
        tick(1);
        `CHK(drv, 4'h0)
        shut = 1'h0;
        trip = 1'h1;
        tick(1);
        `CHK(drv, 4'h0)
        trip = 1'h0;
        tick(1);
        `CHK(drv == 4'h9 || drv == 4'h6, 1'h1)
        hot = 1'h0;
        tick(6);
        `CHK(warn_o, 1'h0)
    endtask
    initial begin
        t_reset;
        t_sign(1'h1);
        t_sign(1'h0);
        t_anti;
        t_brake(1'h1);
        t_brake(1'h0);
        t_reset;
        t_warn;
        conclude;
    end
endmodule
